// [include/rsx_pkg.sv]
// Shared constants and types for the register subtract/xor/swap datapath slice
package rsx_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int NIB_W = 4;

	// ----------------------------------------------------------------
	// Reset values and register address limit
	// ----------------------------------------------------------------
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic FLAG_RST = 1'b0;
	localparam logic [6:0] ADDR_RST = 7'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [6:0] REG_ADDR_MAX = 7'h7f;

	// ----------------------------------------------------------------
	// Result target encoding
	// ----------------------------------------------------------------
	localparam logic TARGET_ACC = 1'b0;
	localparam logic TARGET_REG = 1'b1;

	// ----------------------------------------------------------------
	// Operation codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RSX_OP_IDLE = 2'h0,
		RSX_OP_SUB = 2'h1,
		RSX_OP_XOR = 2'h2,
		RSX_OP_SWAP = 2'h3
	} rsx_op_t;

endpackage

// [hdl/rsx_alu.sv]
// Register subtract, exclusive-or and nibble exchange datapath with status flags
`timescale 1ns/1ps

module rsx_alu #(
	parameter int DATA_W = rsx_pkg::DATA_W,
	parameter int ADDR_W = rsx_pkg::ADDR_W
) (
	input wire logic clock, // 125 MHz core clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic opValid, // Operation request this cycle
	input wire rsx_pkg::rsx_op_t opCode, // Operation select
	input wire logic resultTargetBit, // 0 accumulator, 1 addressed register
	input wire logic [ADDR_W-1:0] operandRegisterAddress, // File register address
	input wire logic [DATA_W-1:0] regReadData, // Content of the addressed register
	input wire logic accLoadValid, // Core loads the accumulator
	input wire logic [DATA_W-1:0] accLoadData, // Value for accumulator load
	output logic [DATA_W-1:0] accumulator, // Accumulator contents
	output logic unsignedOverflowBit, // Carry, set when no borrow
	output logic nibbleOverflowBit, // Low-nibble carry, set when no borrow
	output logic resultNullBit, // Set when the last subtract or xor result was zero
	output logic regWriteValid, // One-cycle register write strobe
	output logic [ADDR_W-1:0] regWriteAddress, // Register write address
	output logic [DATA_W-1:0] regWriteData, // Register write data
	output logic opDone // One-cycle completion pulse
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (DATA_W != 8) begin : g_bad_data
		$error("rsx_alu: DATA_W must be 8");
	end
	if (ADDR_W != 7) begin : g_bad_addr
		$error("rsx_alu: ADDR_W must be 7");
	end

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] accQ, accD;
	logic carryQ, carryD;
	logic nibQ, nibD;
	logic zeroQ, zeroD;
	logic wrValidQ, wrValidD;
	logic [ADDR_W-1:0] wrAddrQ, wrAddrD;
	logic [DATA_W-1:0] wrDataQ, wrDataD;
	logic doneQ;

	wire isSub = opValid && (opCode == rsx_pkg::RSX_OP_SUB);
	wire isXor = opValid && (opCode == rsx_pkg::RSX_OP_XOR);
	wire isSwap = opValid && (opCode == rsx_pkg::RSX_OP_SWAP);
	wire isOp = isSub || isXor || isSwap;
	wire toReg = (resultTargetBit == rsx_pkg::TARGET_REG);

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	// Two's complement subtract; carry means no borrow out of each width
	wire [DATA_W-1:0] subVal = regReadData - accQ;
	wire subNoBorrow = regReadData >= accQ;
	wire nibNoBorrow = regReadData[rsx_pkg::NIB_W-1:0] >= accQ[rsx_pkg::NIB_W-1:0];
	wire [DATA_W-1:0] xorVal = accQ ^ regReadData;
	wire [DATA_W-1:0] swapVal = {regReadData[rsx_pkg::NIB_W-1:0],
		regReadData[DATA_W-1:rsx_pkg::NIB_W]};

	wire [DATA_W-1:0] opResult = isSub ? subVal : (isXor ? xorVal : swapVal);
	wire opZero = (opResult == '0);

	// Flags: subtract updates all three, xor only zero, exchange none
	assign carryD = isSub ? subNoBorrow : carryQ;
	assign nibD = isSub ? nibNoBorrow : nibQ;
	assign zeroD = (isSub || isXor) ? opZero : zeroQ;

	// Result steering; a pending op wins over an accumulator load
	assign accD = (isOp && !toReg) ? opResult :
		((!isOp && accLoadValid) ? accLoadData : accQ);
	assign wrValidD = isOp && toReg;
	assign wrAddrD = (isOp && toReg) ? operandRegisterAddress : wrAddrQ;
	assign wrDataD = (isOp && toReg) ? opResult : wrDataQ;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			accQ <= rsx_pkg::ACC_RST;
			carryQ <= rsx_pkg::FLAG_RST;
			nibQ <= rsx_pkg::FLAG_RST;
			zeroQ <= rsx_pkg::FLAG_RST;
		end else begin
			accQ <= accD;
			carryQ <= carryD;
			nibQ <= nibD;
			zeroQ <= zeroD;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wrValidQ <= 1'b0;
			wrAddrQ <= rsx_pkg::ADDR_RST;
			wrDataQ <= rsx_pkg::DATA_RST;
			doneQ <= 1'b0;
		end else begin
			wrValidQ <= wrValidD;
			wrAddrQ <= wrAddrD;
			wrDataQ <= wrDataD;
			doneQ <= isOp;
		end
	end

	assign accumulator = accQ;
	assign unsignedOverflowBit = carryQ;
	assign nibbleOverflowBit = nibQ;
	assign resultNullBit = zeroQ;
	assign regWriteValid = wrValidQ;
	assign regWriteAddress = wrAddrQ;
	assign regWriteData = wrDataQ;
	assign opDone = doneQ;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_sub_value;
		@(posedge clock) disable iff (!arst_n)
		isSub && !toReg |=> accQ == DATA_W'($past(regReadData) - $past(accQ));
	endproperty
	a_sub_value: assert property (p_sub_value) else $error("subtract result wrong");

	property p_sub_flags;
		@(posedge clock) disable iff (!arst_n)
		isSub |=> (carryQ == ($past(regReadData) >= $past(accQ)))
			&& (nibQ == ($past(regReadData[3:0]) >= $past(accQ[3:0])))
			&& (zeroQ == (wrValidQ ? (wrDataQ == '0) : (accQ == '0)));
	endproperty
	a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

	property p_reg_target;
		@(posedge clock) disable iff (!arst_n)
		(isSub || isXor) && toReg |=> wrValidQ && (wrAddrQ == $past(operandRegisterAddress))
			&& $stable(accQ) && doneQ;
	endproperty
	a_reg_target: assert property (p_reg_target) else $error("register target not written");

	property p_acc_target;
		@(posedge clock) disable iff (!arst_n)
		(isSub || isXor) && !toReg |=> !wrValidQ && doneQ;
	endproperty
	a_acc_target: assert property (p_acc_target) else $error("register written for acc target");

	property p_xor_flags;
		@(posedge clock) disable iff (!arst_n)
		isXor |=> $stable(carryQ) && $stable(nibQ)
			&& (zeroQ == (($past(accQ) ^ $past(regReadData)) == '0));
	endproperty
	a_xor_flags: assert property (p_xor_flags) else $error("xor flag update wrong");

	property p_xor_value;
		@(posedge clock) disable iff (!arst_n)
		isXor && !toReg |=> accQ == ($past(accQ) ^ $past(regReadData));
	endproperty
	a_xor_value: assert property (p_xor_value) else $error("xor result wrong");

	property p_swap_flags;
		@(posedge clock) disable iff (!arst_n)
		isSwap |=> $stable(carryQ) && $stable(nibQ) && $stable(zeroQ);
	endproperty
	a_swap_flags: assert property (p_swap_flags) else $error("exchange changed a flag");

	property p_swap_acc;
		@(posedge clock) disable iff (!arst_n)
		isSwap && !toReg |=> accQ == {$past(regReadData[3:0]), $past(regReadData[7:4])};
	endproperty
	a_swap_acc: assert property (p_swap_acc) else $error("exchange to acc wrong");

	property p_swap_reg;
		@(posedge clock) disable iff (!arst_n)
		isSwap && toReg |=> wrValidQ && $stable(accQ)
			&& wrDataQ == {$past(regReadData[3:0]), $past(regReadData[7:4])}
			&& (wrAddrQ == $past(operandRegisterAddress));
	endproperty
	a_swap_reg: assert property (p_swap_reg) else $error("exchange to register wrong");

	// Register-targeted results carry the computed value
	property p_sub_reg;
		@(posedge clock) disable iff (!arst_n)
		isSub && toReg |=> wrDataQ == DATA_W'($past(regReadData) - $past(accQ));
	endproperty
	a_sub_reg: assert property (p_sub_reg) else $error("subtract to register wrong");

	property p_xor_reg;
		@(posedge clock) disable iff (!arst_n)
		isXor && toReg |=> wrDataQ == ($past(accQ) ^ $past(regReadData));
	endproperty
	a_xor_reg: assert property (p_xor_reg) else $error("xor to register wrong");

	// Accumulator load is taken only when no op is
	property p_load_taken;
		@(posedge clock) disable iff (!arst_n)
		accLoadValid && !isOp |=> accQ == $past(accLoadData);
	endproperty
	a_load_taken: assert property (p_load_taken) else $error("accumulator load lost");

	property p_idle_quiet;
		@(posedge clock) disable iff (!arst_n)
		opValid && (opCode == rsx_pkg::RSX_OP_IDLE) |=> !doneQ && !wrValidQ;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle code acted");

	c_sub_borrow: cover property (@(posedge clock) disable iff (!arst_n)
		isSub && (regReadData < accQ));
	c_xor_zero: cover property (@(posedge clock) disable iff (!arst_n)
		isXor && (regReadData == accQ));
	c_swap_reg: cover property (@(posedge clock) disable iff (!arst_n)
		isSwap && toReg ##1 isSwap && !toReg);
	c_back_to_back: cover property (@(posedge clock) disable iff (!arst_n)
		isSub ##1 isXor ##1 isSwap);
	c_load_refused: cover property (@(posedge clock) disable iff (!arst_n)
		accLoadValid && isOp && !toReg);

endmodule // rsx_alu

// [verif/tb_rsx_alu.sv]
// Self-checking bench for the register subtract/xor/swap datapath
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s expected %h seen %h", n, e, g); end end

module tb_rsx_alu;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic opValid = 1'b0;
	rsx_pkg::rsx_op_t opCode = rsx_pkg::RSX_OP_IDLE;
	logic resultTargetBit = 1'b0;
	logic [6:0] operandRegisterAddress = 7'h00;
	logic [7:0] regReadData = 8'h00;
	logic accLoadValid = 1'b0;
	logic [7:0] accLoadData = 8'h00;
	logic [7:0] accumulator, regWriteData;
	logic unsignedOverflowBit, nibbleOverflowBit, resultNullBit, regWriteValid, opDone;
	logic [6:0] regWriteAddress;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	rsx_alu dut (.clock(clock), .arst_n(arst_n), .opValid(opValid), .opCode(opCode),
		.resultTargetBit(resultTargetBit), .operandRegisterAddress(operandRegisterAddress),
		.regReadData(regReadData), .accLoadValid(accLoadValid), .accLoadData(accLoadData),
		.accumulator(accumulator), .unsignedOverflowBit(unsignedOverflowBit),
		.nibbleOverflowBit(nibbleOverflowBit), .resultNullBit(resultNullBit),
		.regWriteValid(regWriteValid), .regWriteAddress(regWriteAddress),
		.regWriteData(regWriteData), .opDone(opDone));

	// ----------------------------------------------------------------
	// Clock, watchdog and helpers
	// ----------------------------------------------------------------
	initial begin
		forever #4 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic run_op(input rsx_pkg::rsx_op_t c, input logic t, input logic [6:0] a,
			input logic [7:0] d);
		@(posedge clock);
		opValid <= 1'b1;
		opCode <= c;
		resultTargetBit <= t;
		operandRegisterAddress <= a;
		regReadData <= d;
		@(posedge clock);
		opValid <= 1'b0;
		#1;
		`CHK("opDone", c != rsx_pkg::RSX_OP_IDLE, opDone)
		`CHK("wrValid", t && c != rsx_pkg::RSX_OP_IDLE, regWriteValid)
	endtask

	task automatic load_acc(input logic [7:0] v);
		@(posedge clock);
		accLoadValid <= 1'b1;
		accLoadData <= v;
		@(posedge clock);
		accLoadValid <= 1'b0;
	endtask

	task automatic chk_out(input logic [7:0] acc, input logic c, input logic h, input logic z);
		`CHK("acc", acc, accumulator)
		`CHK("carry", c, unsignedOverflowBit)
		`CHK("nibble", h, nibbleOverflowBit)
		`CHK("null", z, resultNullBit)
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_sub();
		load_acc(8'h01);
		run_op(rsx_pkg::RSX_OP_SUB, 1'b1, rsx_pkg::REG_ADDR_MAX, 8'h10);
		`CHK("wrData", 8'h0f, regWriteData)
		`CHK("wrAddr", rsx_pkg::REG_ADDR_MAX, regWriteAddress)
		chk_out(8'h01, 1'b1, 1'b0, 1'b0);
		run_op(rsx_pkg::RSX_OP_SUB, 1'b0, 7'h00, 8'h00);
		chk_out(8'hff, 1'b0, 1'b0, 1'b0);
		load_acc(8'h33);
		run_op(rsx_pkg::RSX_OP_SUB, 1'b0, 7'h12, 8'h33);
		chk_out(8'h00, 1'b1, 1'b1, 1'b1);
		$display("test_sub done");
	endtask

	task automatic test_xor();
		load_acc(8'h3c);
		run_op(rsx_pkg::RSX_OP_XOR, 1'b0, 7'h01, 8'hc3);
		chk_out(8'hff, 1'b1, 1'b1, 1'b0);
		run_op(rsx_pkg::RSX_OP_XOR, 1'b1, 7'h40, 8'hff);
		`CHK("wrData", 8'h00, regWriteData)
		`CHK("wrAddr", 7'h40, regWriteAddress)
		chk_out(8'hff, 1'b1, 1'b1, 1'b1);
		$display("test_xor done");
	endtask

	task automatic test_swap();
		run_op(rsx_pkg::RSX_OP_SWAP, 1'b0, 7'h02, 8'ha5);
		chk_out(8'h5a, 1'b1, 1'b1, 1'b1);
		run_op(rsx_pkg::RSX_OP_SWAP, 1'b1, 7'h55, 8'h3c);
		`CHK("wrData", 8'hc3, regWriteData)
		`CHK("wrAddr", 7'h55, regWriteAddress)
		chk_out(8'h5a, 1'b1, 1'b1, 1'b1);
		run_op(rsx_pkg::RSX_OP_IDLE, 1'b1, 7'h03, 8'h00);
		chk_out(8'h5a, 1'b1, 1'b1, 1'b1);
		$display("test_swap done");
	endtask

	// Back-to-back ops, the xor using the subtract result; a load beside an op is ignored
	task automatic test_chain();
		load_acc(8'h20);
		@(posedge clock);
		opValid <= 1'b1;
		opCode <= rsx_pkg::RSX_OP_SUB;
		resultTargetBit <= 1'b0;
		regReadData <= 8'h13;
		@(posedge clock);
		opCode <= rsx_pkg::RSX_OP_XOR;
		regReadData <= 8'hf3;
		#1;
		chk_out(8'hf3, 1'b0, 1'b1, 1'b0);
		@(posedge clock);
		opCode <= rsx_pkg::RSX_OP_SWAP;
		resultTargetBit <= 1'b1;
		operandRegisterAddress <= 7'h11;
		regReadData <= 8'h81;
		#1;
		chk_out(8'h00, 1'b0, 1'b1, 1'b1);
		@(posedge clock);
		resultTargetBit <= 1'b0;
		regReadData <= 8'h7e;
		accLoadValid <= 1'b1;
		accLoadData <= 8'h99;
		#1;
		`CHK("wrData", 8'h18, regWriteData)
		`CHK("wrAddr", 7'h11, regWriteAddress)
		chk_out(8'h00, 1'b0, 1'b1, 1'b1);
		@(posedge clock);
		opValid <= 1'b0;
		accLoadValid <= 1'b0;
		#1;
		`CHK("wrValid", 1'b0, regWriteValid)
		chk_out(8'he7, 1'b0, 1'b1, 1'b1);
		$display("test_chain done");
	endtask

	// Reset in mid-run clears all state; the block works again after release
	task automatic test_reset();
		@(posedge clock);
		arst_n <= 1'b0;
		#1;
		chk_out(8'h00, 1'b0, 1'b0, 1'b0);
		`CHK("wrAddr", 7'h00, regWriteAddress)
		`CHK("wrData", 8'h00, regWriteData)
		`CHK("wrValid", 1'b0, regWriteValid)
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		run_op(rsx_pkg::RSX_OP_SUB, 1'b0, 7'h00, 8'h05);
		chk_out(8'h05, 1'b1, 1'b1, 1'b0);
		$display("test_reset done");
	endtask

	initial begin
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		#1;
		chk_out(8'h00, 1'b0, 1'b0, 1'b0);
		test_sub();
		test_xor();
		test_swap();
		test_chain();
		test_reset();
		give_verdict();
	end
endmodule // tb_rsx_alu
